// File: logic/amp_serial_pkg.sv
// package: address, field positions, reset values and states of the amplifier serial port
package amp_serial_pkg;
  // bus address: upper seven bits of the address byte D8 with direction bit clear
  localparam logic [6:0] DEVICE_ADDR = 7'h6C;
  localparam int DIR_BIT = 0;              // address byte bit 0: 1 = device is read
  // byte framing
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;   // bit count when the eighth bit arrives
  localparam logic [3:0] ACK_SLOT = 4'h8;        // bit count during the acknowledge pulse
  localparam logic [1:0] LAST_INSTR_IDX = 2'h1;  // two instruction bytes, index 0 and 1
  localparam logic [1:0] LAST_DIAG_IDX = 2'h3;   // four diagnostic bytes, index 0 to 3
  localparam int CHANNELS = 4;             // 0 front-left, 1 rear-left, 2 front-right, 3 rear-right
  // instruction byte one fields
  localparam int ONE_DIAG_EN = 6;
  localparam int ONE_OFFSET_EN = 5;
  localparam int ONE_FRONT_GAIN = 4;       // 1 = 12dB, 0 = 26dB
  localparam int ONE_REAR_GAIN = 3;
  localparam int ONE_FRONT_UNMUTE = 2;
  localparam int ONE_REAR_UNMUTE = 1;
  localparam int ONE_CLIP_SEL = 0;         // 1 = 10% threshold, 0 = 2%
  // instruction byte two fields
  localparam int TWO_STANDBY_OFF = 4;
  localparam int TWO_LINE_DRIVER = 3;
  localparam int TWO_CURRENT_EN = 2;
  // diagnostic byte fields, common per channel
  localparam int DIAG_TOP_HI = 7;
  localparam int DIAG_TOP_LO = 6;
  localparam int DIAG_CURRENT = 5;
  localparam int DIAG_PERMANENT = 4;
  localparam int DIAG_SHORT_LOAD = 3;
  localparam int DIAG_OPEN_OFFSET = 2;
  localparam int DIAG_SHORT_SUPPLY = 1;
  localparam int DIAG_SHORT_GROUND = 0;
  // reset values of the stored instruction bytes: standby, muted, diagnostics off
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  // link-side protocol states
  typedef enum logic [1:0] {
    LINK_ADDR = 2'b00,
    LINK_WRITE = 2'b01,
    LINK_READ = 2'b10,
    LINK_IGNORE = 2'b11
  } link_state_type;
endpackage

// File: logic/amp_control_diag_serial_port.sv
// two-wire slave port carrying amplifier instruction bytes in and diagnostic bytes out
`timescale 1ns/10ps
module amp_control_diag_serial_port (
  // system clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  // two-wire link: clock line and open-drain data line
  input wire logic SCL_CLK,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // amplifier control from instruction byte one
  output logic DIAG_EN,
  output logic OFFSET_EN,
  output logic FRONT_GAIN_LOW,
  output logic REAR_GAIN_LOW,
  output logic FRONT_UNMUTE,
  output logic REAR_UNMUTE,
  output logic CLIP_THRESH_HIGH,
  // amplifier control from instruction byte two
  output logic STANDBY_OFF,
  output logic LINE_DRIVER_DIAG,
  output logic CURRENT_DIAG_EN,
  // diagnostic cycle restart request
  output logic DIAG_RESTART,
  // status from the diagnostic circuits
  input wire logic THERMAL_WARN,
  input wire logic DIAG_DONE,
  input wire logic [amp_serial_pkg::CHANNELS-1:0] CH_LOW_CURRENT,
  input wire logic [amp_serial_pkg::CHANNELS-1:0] CH_PERMANENT,
  input wire logic [amp_serial_pkg::CHANNELS-1:0] CH_SHORT_LOAD,
  input wire logic [amp_serial_pkg::CHANNELS-1:0] CH_OPEN_LOAD,
  input wire logic [amp_serial_pkg::CHANNELS-1:0] CH_OFFSET_FAULT,
  input wire logic [amp_serial_pkg::CHANNELS-1:0] CH_SHORT_SUPPLY,
  input wire logic [amp_serial_pkg::CHANNELS-1:0] CH_SHORT_GROUND
);
  import amp_serial_pkg::*;

  // ---------------- system clock domain ----------------
  logic sda_s1_r, sda_s2_r, sda_d_r;      // data line synchroniser and delay
  logic scl_s1_r, scl_s2_r, scl_d_r;      // clock line synchroniser and delay
  logic start_det, stop_det, scl_fall;    // decoded line events
  logic frame_active_r;                   // between start and stop
  logic armed_r;                          // start seen, first clock fall not yet seen
  logic drive_ok_r;                       // link state is defined, data may be driven
  logic link_seen_r;                      // link side rebuilt since reset
  logic wr_s1_r, wr_s2_r, wr_s3_r;        // write-complete level crossing
  logic rd_s1_r, rd_s2_r, rd_s3_r;        // read-start level crossing
  logic wr_event, rd_event;               // one-cycle events in system domain
  logic [7:0] ctrl_one_r;                 // stored instruction byte one
  logic [7:0] ctrl_two_r;                 // stored instruction byte two
  logic [CHANNELS-1:0] offset_keep_r;     // offset fault held through the window
  logic [CHANNELS-1:0] open_or_offset;    // per-channel bit two source
  wire logic [8*CHANNELS-1:0] diag_word;  // live assembled diagnostic bytes
  logic [8*CHANNELS-1:0] diag_hold_r;     // frozen copy handed to the link
  logic restart_r;                        // restart pulse register

  // ---------------- link clock domain ----------------
  link_state_type state_r;                // protocol state
  logic arm_s1_r;                         // start arming crossing into link domain
  logic [3:0] bit_cnt_r;                  // 0..7 data bits, 8 acknowledge slot
  logic [1:0] byte_idx_r;                 // byte number after the address
  logic [7:0] shift_r;                    // incoming byte
  logic [7:0] rx_byte;                    // complete byte on its eighth bit
  logic ack_r;                            // device acknowledges in this slot
  logic master_slot_r;                    // slot belongs to the master (read data)
  logic [7:0] one_hold_r, two_hold_r;     // received instruction bytes
  logic wr_done_r;                        // both instruction bytes taken
  logic rd_start_r;                       // read addressed in this frame
  logic oe_r;                             // pull data line low
  logic tx_bit;                           // bit being returned
  logic [4:0] tx_idx;                     // index into the frozen diagnostic word

  // line events from the synchronised levels, one cycle each
  assign start_det = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
  assign stop_det = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;
  assign scl_fall = scl_d_r && !scl_s2_r;
  // transfer events wait until the link side has been rebuilt once, so
  // power-up contents of the link flops can never pass for a transfer
  assign wr_event = link_seen_r && wr_s2_r && !wr_s3_r;
  assign rd_event = link_seen_r && rd_s2_r && !rd_s3_r;

  // two-flop synchronisers for the bus lines, third flop for edge finding
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
    end else if (CE) begin
      sda_s1_r <= SDA_IN;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
      scl_s1_r <= SCL_CLK;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
    end
  end

  // frame tracking: start opens, stop closes, repeated start re-arms
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      frame_active_r <= 1'b0;
      armed_r <= 1'b0;
      drive_ok_r <= 1'b0;
      link_seen_r <= 1'b0;
    end else if (CE) begin
      if (start_det) begin
        frame_active_r <= 1'b1;
        armed_r <= 1'b1;
        drive_ok_r <= 1'b0;
      end else if (stop_det) begin
        frame_active_r <= 1'b0;
        armed_r <= 1'b0;
        drive_ok_r <= 1'b0;
      end else if (scl_fall && armed_r) begin
        // first fall has loaded the arming flop on the link side
        armed_r <= 1'b0;
      end else if (scl_fall && frame_active_r) begin
        // link state was rebuilt on the first rise, driving is safe
        drive_ok_r <= 1'b1;
        // from here on the link flops hold known levels, events are trusted
        link_seen_r <= 1'b1;
      end
    end
  end

  // crossing of write-complete and read-start levels into system clock
  // each level holds until the first rise of the next frame
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_s1_r <= 1'b0;
      wr_s2_r <= 1'b0;
      wr_s3_r <= 1'b0;
      rd_s1_r <= 1'b0;
      rd_s2_r <= 1'b0;
      rd_s3_r <= 1'b0;
    end else if (CE) begin
      wr_s1_r <= wr_done_r;
      wr_s2_r <= wr_s1_r;
      wr_s3_r <= wr_s2_r;
      rd_s1_r <= rd_start_r;
      rd_s2_r <= rd_s1_r;
      rd_s3_r <= rd_s2_r;
    end
  end

  // instruction bytes take effect together once the eighth bit of the second has been received
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_one_r <= CTRL_ONE_RESET;
      ctrl_two_r <= CTRL_TWO_RESET;
    end else if (CE && wr_event) begin
      ctrl_one_r <= one_hold_r;
      ctrl_two_r <= two_hold_r;
    end
  end

  // control outputs straight from the stored bytes
  // reserved instruction bits are kept but drive nothing
  assign DIAG_EN = ctrl_one_r[ONE_DIAG_EN];
  assign OFFSET_EN = ctrl_one_r[ONE_OFFSET_EN];
  assign FRONT_GAIN_LOW = ctrl_one_r[ONE_FRONT_GAIN];
  assign REAR_GAIN_LOW = ctrl_one_r[ONE_REAR_GAIN];
  assign FRONT_UNMUTE = ctrl_one_r[ONE_FRONT_UNMUTE];
  assign REAR_UNMUTE = ctrl_one_r[ONE_REAR_UNMUTE];
  assign CLIP_THRESH_HIGH = ctrl_one_r[ONE_CLIP_SEL];
  assign STANDBY_OFF = ctrl_two_r[TWO_STANDBY_OFF];
  assign LINE_DRIVER_DIAG = ctrl_two_r[TWO_LINE_DRIVER];
  assign CURRENT_DIAG_EN = ctrl_two_r[TWO_CURRENT_EN];

  // offset window: opens at a read or when offset detection is switched on,
  // a channel keeps its flag only while the fault stays present throughout
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      offset_keep_r <= '0;
    end else if (CE) begin
      if (rd_event || (wr_event && one_hold_r[ONE_OFFSET_EN] && !ctrl_one_r[ONE_OFFSET_EN])) begin
        offset_keep_r <= CH_OFFSET_FAULT;
      end else begin
        offset_keep_r <= offset_keep_r & CH_OFFSET_FAULT;
      end
    end
  end

  // restart request to the diagnostic circuits on every addressed read
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      restart_r <= 1'b0;
    end else if (CE) begin
      restart_r <= rd_event;
    end
  end
  assign DIAG_RESTART = restart_r;

  // bit two shows offset while offset detection runs, open load otherwise
  assign open_or_offset = ctrl_one_r[ONE_OFFSET_EN] ? offset_keep_r : CH_OPEN_LOAD;

  // per-channel low six bits of each diagnostic byte
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
      assign diag_word[8*ch+DIAG_CURRENT] = CH_LOW_CURRENT[ch];
      assign diag_word[8*ch+DIAG_PERMANENT] = CH_PERMANENT[ch];
      assign diag_word[8*ch+DIAG_SHORT_LOAD] = CH_SHORT_LOAD[ch];
      assign diag_word[8*ch+DIAG_OPEN_OFFSET] = open_or_offset[ch];
      assign diag_word[8*ch+DIAG_SHORT_SUPPLY] = CH_SHORT_SUPPLY[ch];
      assign diag_word[8*ch+DIAG_SHORT_GROUND] = CH_SHORT_GROUND[ch];
    end
  endgenerate

  // top two bits of each diagnostic byte
  assign diag_word[DIAG_TOP_HI] = THERMAL_WARN;
  assign diag_word[DIAG_TOP_LO] = DIAG_DONE;
  assign diag_word[8+DIAG_TOP_HI] = ctrl_one_r[ONE_OFFSET_EN];
  assign diag_word[8+DIAG_TOP_LO] = ctrl_two_r[TWO_CURRENT_EN];
  assign diag_word[16+DIAG_TOP_HI] = ctrl_two_r[TWO_STANDBY_OFF];
  assign diag_word[16+DIAG_TOP_LO] = ctrl_one_r[ONE_DIAG_EN];
  assign diag_word[24+DIAG_TOP_HI] = 1'b0;
  assign diag_word[24+DIAG_TOP_LO] = 1'b0;

  // results are frozen for the whole frame, so a read returns what the
  // previous cycle produced while the restart only affects later reads
  // the link reads this copy bit by bit, so it must not move inside a frame
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      diag_hold_r <= '0;
    end else if (CE && !frame_active_r) begin
      diag_hold_r <= diag_word;
    end
  end

  // ---------------- link clock domain logic ----------------

  // arming crossing: one flop on the falling edge that ends the start.
  // the clock line gives no other edge before the first rise, so a second
  // link flop would arm one bit late and shift the address by one place.
  // the flop is safe: arming settles within three system cycles of the
  // start while the clock must stay high for at least four, and it clears
  // within three cycles of that fall, long before the next fall samples it
  always_ff @(negedge SCL_CLK) begin
    arm_s1_r <= armed_r;
  end

  // complete byte as it stands on the eighth rising edge, msb first
  assign rx_byte = {shift_r[6:0], SDA_IN};

  // bit sampling on rising edges, where the master keeps data steady
  always_ff @(posedge SCL_CLK) begin
    if (arm_s1_r) begin
      // first bit of the address byte, on the first rise after the start
      // (the arming flop was set by the fall that ends the start condition)
      state_r <= LINK_ADDR;
      bit_cnt_r <= 4'h1;
      shift_r <= {7'h00, SDA_IN};
      byte_idx_r <= 2'h0;
      ack_r <= 1'b0;
      master_slot_r <= 1'b0;
      wr_done_r <= 1'b0;
      rd_start_r <= 1'b0;
    end else if (bit_cnt_r == ACK_SLOT) begin
      // acknowledge pulse: end of one byte slot
      bit_cnt_r <= 4'h0;
      ack_r <= 1'b0;
      if (master_slot_r) begin
        master_slot_r <= 1'b0;
        if (SDA_IN || byte_idx_r == LAST_DIAG_IDX) begin
          // master did not acknowledge, or all bytes sent
          state_r <= LINK_IGNORE;
        end else begin
          byte_idx_r <= byte_idx_r + 2'h1;
        end
      end
    end else begin
      // data bit, shifted in msb first
      shift_r <= rx_byte;
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (bit_cnt_r == LAST_DATA_BIT) begin
        case (state_r)
          LINK_ADDR: begin
            if (rx_byte[7:1] == DEVICE_ADDR) begin
              ack_r <= 1'b1;
              if (rx_byte[DIR_BIT]) begin
                state_r <= LINK_READ;
                rd_start_r <= 1'b1;
              end else begin
                state_r <= LINK_WRITE;
              end
            end else begin
              state_r <= LINK_IGNORE;
            end
          end
          LINK_WRITE: begin
            if (byte_idx_r == 2'h0) begin
              one_hold_r <= rx_byte;
              ack_r <= 1'b1;
              byte_idx_r <= LAST_INSTR_IDX;
            end else if (byte_idx_r == LAST_INSTR_IDX) begin
              two_hold_r <= rx_byte;
              ack_r <= 1'b1;
              wr_done_r <= 1'b1;
              byte_idx_r <= 2'h2;
            end else begin
              // surplus byte is refused
              state_r <= LINK_IGNORE;
            end
          end
          LINK_READ: begin
            // the master owns the coming slot
            master_slot_r <= 1'b1;
          end
          default: begin
            // foreign or finished frame: nothing to do
            state_r <= LINK_IGNORE;
          end
        endcase
      end
    end
  end

  // bit returned during a read: byte selected by index, msb first
  assign tx_idx = {byte_idx_r, ~bit_cnt_r[2:0]};
  assign tx_bit = diag_hold_r[tx_idx];

  // data line driven only from falling edges, so it never moves while clock is high
  // stale state from an earlier frame is masked until driving is permitted
  always_ff @(negedge SCL_CLK) begin
    if (bit_cnt_r == ACK_SLOT) begin
      oe_r <= ack_r;
    end else if (state_r == LINK_READ) begin
      oe_r <= !tx_bit;
    end else begin
      oe_r <= 1'b0;
    end
  end

  // open drain: line only pulled low, released outside an active frame
  // the pin never shows a high level of its own, the pull-up provides it
  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe_r && drive_ok_r && frame_active_r;

endmodule

// File: tb/amp_serial_asserts.sv
// concurrent checks on the amplifier serial port pins
`timescale 1ns/10ps
module amp_serial_asserts (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // link pins
  input wire logic SCL_CLK,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  // controls and restart pulse
  input wire logic DIAG_EN,
  input wire logic STANDBY_OFF,
  input wire logic FRONT_UNMUTE,
  input wire logic CURRENT_DIAG_EN,
  input wire logic DIAG_RESTART
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // device starts pulling the data wire
  sequence pull_start;
    $rose(SDA_OE);
  endsequence
  // any sampled control level moves
  sequence ctrl_moves;
    $changed({DIAG_EN, STANDBY_OFF, FRONT_UNMUTE, CURRENT_DIAG_EN});
  endsequence
  a_pull_only_low: assert property (SDA_OUT == 1'b0) else $error("data driven high");
  a_reset_quiet: assert property (disable iff (1'b0) RST |=> !SDA_OE && !DIAG_RESTART)
    else $error("pin or pulse active after reset");
  a_ctrl_reset: assert property (disable iff (1'b0) RST |=> !DIAG_EN && !STANDBY_OFF && !FRONT_UNMUTE)
    else $error("controls not cleared by reset");
  a_restart_single: assert property (DIAG_RESTART |=> !DIAG_RESTART) else $error("restart wider than one");
  a_restart_acked: assert property ($rose(DIAG_RESTART) |-> ##[0:4] SDA_OE) else $error("restart without ack");
  a_ctrl_acked: assert property (ctrl_moves |-> ##[0:4] SDA_OE) else $error("controls moved without ack");
  a_oe_clock_low: assert property ($changed(SDA_OE) |-> !SCL_CLK) else $error("data moved with clock high");
  a_oe_stands: assert property (pull_start |=> SDA_OE [*4]) else $error("pull released early");
endmodule
bind amp_control_diag_serial_port amp_serial_asserts i_amp_serial_asserts (.CLK_SYS(CLK_SYS), .RST(RST),
  .SCL_CLK(SCL_CLK), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .DIAG_EN(DIAG_EN), .STANDBY_OFF(STANDBY_OFF),
  .FRONT_UNMUTE(FRONT_UNMUTE), .CURRENT_DIAG_EN(CURRENT_DIAG_EN), .DIAG_RESTART(DIAG_RESTART));

// File: tb/bus_host_model.sv
// bus master model: clock line and open-drain data pull
`timescale 1ns/10ps
module bus_host_model (
  // resolved data wire
  input wire logic sda,
  // clock line and data pull
  output logic scl,
  output logic sda_low
);
  // bus idles released with the clock high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bit: data set while clock low, sampled at the rise
  task automatic bit_io(input logic b, output logic s);
    #20 sda_low = ~b;
    #60 scl = 1'b1;
    #2 s = sda;
    #78 scl = 1'b0;
  endtask
  // start: data falls with clock high, long first low
  task automatic start_cond();
    #20 sda_low = 1'b0;
    #20 scl = 1'b1;
    #80 sda_low = 1'b1;
    #120 scl = 1'b0;
    #40;
  endtask
  // stop: data rises with clock high, then bus free
  task automatic stop_cond();
    #20 sda_low = 1'b1;
    #60 scl = 1'b1;
    #80 sda_low = 1'b0;
    #160;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] tx, input logic slot, output logic [7:0] rx, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(slot, s);
    acked = ~s;
  endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the amplifier serial port
`timescale 1ns/10ps
module testbench;
  import amp_serial_pkg::*;
  logic clk_sys = 1'b0; // system clock
  logic rst = 1'b1; // synchronous reset
  logic ce = 1'b1; // clock enable, held on
  logic thermal = 1'b0; // thermal warning
  logic done = 1'b0; // diagnostic cycle done
  logic [3:0] ch [7] = '{default: 4'h0}; // low current, permanent, load, open, offset, supply, ground
  wire [9:0] ctl; // byte one bits 6..0 then byte two bits 4..2
  wire sda_out, sda_oe, restart, scl, host_low;
  wire sda = (sda_oe ? sda_out : 1'b1) & ~host_low; // open-drain wire with pull-up
  int errors = 0;
  int total_checks = 0;
  int restarts = 0; // restart pulses seen
  logic [7:0] b1s = 8'h00, b2s = 8'h00; // last applied instruction bytes
  logic [7:0] rxb [4]; // bytes read back
  logic [4:0] ack; // acknowledge per byte
  logic [7:0] junk; // unused receive data
  logic [7:0] bad [4] = '{8'hDA, 8'h58, 8'hD0, 8'hDB}; // foreign addresses
  amp_control_diag_serial_port i_amp_control_diag_serial_port (
    .CLK_SYS(clk_sys), .RST(rst), .CE(ce), .SCL_CLK(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .DIAG_EN(ctl[9]), .OFFSET_EN(ctl[8]), .FRONT_GAIN_LOW(ctl[7]), .REAR_GAIN_LOW(ctl[6]),
    .FRONT_UNMUTE(ctl[5]), .REAR_UNMUTE(ctl[4]), .CLIP_THRESH_HIGH(ctl[3]), .STANDBY_OFF(ctl[2]),
    .LINE_DRIVER_DIAG(ctl[1]), .CURRENT_DIAG_EN(ctl[0]), .DIAG_RESTART(restart), .THERMAL_WARN(thermal),
    .DIAG_DONE(done), .CH_LOW_CURRENT(ch[0]), .CH_PERMANENT(ch[1]), .CH_SHORT_LOAD(ch[2]),
    .CH_OPEN_LOAD(ch[3]), .CH_OFFSET_FAULT(ch[4]), .CH_SHORT_SUPPLY(ch[5]), .CH_SHORT_GROUND(ch[6]));
  bus_host_model host (.sda(sda), .scl(scl), .sda_low(host_low));
  // 25 ns system clock
  always #12.5 clk_sys = ~clk_sys;
  // count restart pulses
  always @(posedge clk_sys) if (restart === 1'b1) restarts++;
  // compare and count
  task automatic check(input logic [15:0] seen, want, input string what);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, want);
    end
  endtask
  // expected control levels from the shadow bytes
  function automatic logic [15:0] exp_ctl();
    return 16'({b1s[6:0], b2s[4:2]});
  endfunction
  // expected diagnostic byte k
  function automatic logic [7:0] diag_exp(input int k, input logic [3:0] ow);
    logic [1:0] top;
    case (k)
      0: top = {thermal, done};
      1: top = {b1s[5], b2s[2]};
      2: top = {b2s[4], b1s[6]};
      default: top = 2'b00;
    endcase
    return {top, ch[0][k], ch[1][k], ch[2][k], b1s[5] ? ow[k] : ch[3][k], ch[5][k], ch[6][k]};
  endfunction
  // one frame: address then n bytes; a read acks all but the last
  task automatic frame(input logic [7:0] adr, d0, d1, d2, input int n);
    logic [7:0] d [3];
    d = '{d0, d1, d2};
    host.start_cond();
    host.byte_io(adr, 1'b1, junk, ack[0]);
    for (int k = 0; k < n; k++)
      host.byte_io(adr[0] ? 8'hFF : d[k], adr[0] ? k == n - 1 : 1'b1, rxb[k], ack[k + 1]);
    host.stop_cond();
  endtask
  // write both instruction bytes and compare
  task automatic write_ctl(input logic [7:0] v1, v2);
    int r0;
    r0 = restarts;
    frame(8'hD8, v1, v2, 8'h00, 2);
    b1s = v1;
    b2s = v2;
    check(16'(ack[2:0]), 16'h0007, "write acks");
    check(16'(ctl), exp_ctl(), "controls");
    check(16'(restarts - r0), 16'h0000, "restart on write");
  endtask
  // read four diagnostic bytes and compare
  task automatic read_diag(input logic [3:0] ow);
    int r0;
    r0 = restarts;
    frame(8'hD9, 8'h00, 8'h00, 8'h00, 4);
    check(16'(ack[0]), 16'h0001, "read address ack");
    for (int k = 0; k < 4; k++) check(16'(rxb[k]), 16'(diag_exp(k, ow)), "diag byte");
    check(16'(restarts - r0), 16'h0001, "restart count");
  endtask
  // status change just after a clock edge
  task automatic set_offset(input logic [3:0] v);
    @(posedge clk_sys);
    #2 ch[4] = v;
  endtask
  // counts, verdict, end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    int r0; // restart count before the foreign frames
    void'($urandom(32'h4837));
    repeat (16) @(posedge clk_sys);
    #2 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    check(16'(ctl), 16'h0000, "reset controls");
    $display("test reset done");
    for (int t = 0; t < 8; t++) begin
      logic [7:0] r;
      r = 8'($urandom);
      if (t == 0) write_ctl(8'h5F, 8'h1C);
      else if (t == 1) write_ctl(8'h00, 8'h00);
      else write_ctl({1'b0, r[6], 1'b0, r[4:0]}, {3'b000, r[7], r[5], r[0], 2'b00});
      @(posedge clk_sys);
      #2 thermal = 1'($urandom);
      done = 1'($urandom);
      foreach (ch[j]) ch[j] = 4'($urandom);
      read_diag(4'h0);
    end
    $display("test write and read done");
    r0 = restarts;
    foreach (bad[i]) begin
      frame(bad[i], 8'h7F, 8'h1C, 8'h00, bad[i][0] ? 4 : 2);
      check(16'(ack[0]), 16'h0000, "foreign ack");
      check(16'(ctl), exp_ctl(), "foreign ignored");
    end
    check(16'(restarts - r0), 16'h0000, "foreign restart");
    frame(8'hD8, 8'h46, 8'h18, 8'h7F, 3);
    b1s = 8'h46;
    b2s = 8'h18;
    check(16'(ack[3:0]), 16'h0007, "third byte ack");
    check(16'(ctl), exp_ctl(), "third byte controls");
    frame(8'hD8, 8'h00, 8'h00, 8'h00, 1);
    check(16'(ctl), exp_ctl(), "single byte ignored");
    $display("test refusals done");
    set_offset(4'hB);
    write_ctl(8'h60, 8'h10);
    read_diag(4'hB);
    set_offset(4'h3);
    set_offset(4'hB);
    read_diag(4'h3);
    read_diag(4'hB);
    $display("test offset window done");
    print_verdict();
  end
  // watchdog, several times the expected run
  initial begin
    #2000000;
    errors++;
    print_verdict();
  end
endmodule
